// *** rtc_prescale_wakeup_alarm.v ***
// Operation
// - First-stage clock is source clock divided by async factor plus one, bits 22:16.
// - One-second tick is first-stage clock divided by sync factor plus one, bits 14:0.
// - Backup reset loads divider factors with 0x007F00FF; system reset leaves it.
// - Divider, trim and alarm registers accept writes only in initialization state.
// - When enabled, wakeup flag sets every reload plus one wakeup clock periods, with 65536 more added for select 6 or 7.
// - Wakeup reload register accepts writes only while write-allowed flag is one.
// - Backup reset loads wakeup reload with 0x0000FFFF; system reset leaves it.
// - Trim direction bit 7: zero speeds calendar up, one slows it down.
// - Direction zero: each step count adds about 4 ppm.
// - Direction one: each step count removes about 2 ppm.
// - Backup reset clears trim and alarm registers; system reset leaves them.
// - Weekday select bit 30 makes day units a weekday and ignores day tens.
// - Alarm day is BCD: tens in 29:28, units or weekday in 27:24.
// - Alarm hour is BCD: tens in 21:20, units in 19:16.
// - Alarm minutes 14:12 and 11:8, seconds 6:4 and 3:0, in BCD.
// - Afternoon bit 22 qualifies the alarm hour.
// - Alarm flag sets when current time matches alarm settings, masked fields ignored.
// - Wakeup flag rises when the down-counter expires; software clears by writing zero.
// - Init-state flag one allows divider changes; zero blocks them.
`timescale 1ns/1ps
`include "rtc_map.vh"

module rtc_prescale_wakeup_alarm #(
    parameter TRIM_WIN_W = `TRIM_WIN_W
) (
    // Clock and backup-domain reset
    input wire i_core_clk,
    input wire i_nrst,
    // Register port
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // Current calendar, alarm layout without masks, plus weekday
    input wire [31:0] i_cur_time,
    input wire [3:0] i_cur_weekday,
    // Event and clock outputs
    output reg o_first_stage_clock,
    output reg o_one_second_tick,
    output reg o_wakeup_flag,
    output reg o_first_alarm_flag,
    output reg o_init_state_flag
);

    // Software-visible configuration
    reg [6:0] factor_a;
    reg [14:0] factor_s;
    reg [15:0] wakeup_reload_value;
    reg coarse_trim_direction;
    reg [4:0] coarse_trim_step;
    reg [31:0] alarm;

    // Control and status
    reg init_mode_request;
    reg wakeup_enable;
    reg [2:0] wakeup_clock_select;

    // Internal counters
    reg wakeup_run;
    reg [6:0] a_cnt;
    reg [14:0] s_cnt;
    reg [TRIM_WIN_W-1:0] win_cnt;
    reg [3:0] pre_div;
    reg [16:0] wk_cnt;
    reg [31:0] next_rdata;

    // Register write decode
    wire wr_div = i_wr && (i_addr == `OFS_DIV_FACTORS);
    wire wr_reload = i_wr && (i_addr == `OFS_WAKEUP_RELOAD);
    wire wr_trim = i_wr && (i_addr == `OFS_COARSE_TRIM);
    wire wr_alarm = i_wr && (i_addr == `OFS_ALARM0);
    wire wr_ctrl = i_wr && (i_addr == `OFS_WAKEUP_CTRL);
    wire wr_status = i_wr && (i_addr == `OFS_STATUS);

    // Reload may change only while the timer is stopped and settled
    wire wakeup_write_allowed = !wakeup_enable && !wakeup_run;

    // Wakeup counting clock: source divided by 16, 8, 4, 2, or the one-second tick
    function wk_clk_hit;
        input [2:0] sel;
        input [3:0] div;
        input tick;
        begin
            case (sel)
                3'h0: wk_clk_hit = (div == 4'hF);
                3'h1: wk_clk_hit = (div[2:0] == 3'h7);
                3'h2: wk_clk_hit = (div[1:0] == 2'h3);
                3'h3: wk_clk_hit = div[0];
                default: wk_clk_hit = tick;
            endcase
        end
    endfunction

    // BCD field compare with mask
    function field_match;
        input mask;
        input [6:0] cur;
        input [6:0] set;
        begin
            field_match = mask || (cur == set);
        end
    endfunction

    // Trim window compares, half window for speed-up and full window for slow-down
    wire [TRIM_WIN_W-2:0] step_half = {{(TRIM_WIN_W-6){1'b0}}, coarse_trim_step};
    wire [TRIM_WIN_W-1:0] step_full = {{(TRIM_WIN_W-5){1'b0}}, coarse_trim_step};
    wire trim_extra = !coarse_trim_direction && (win_cnt[TRIM_WIN_W-2:0] < step_half);
    wire trim_skip = coarse_trim_direction && (win_cnt < step_full);

    // Prescaler chain with coarse trim
    wire stage_hit = !o_init_state_flag && (a_cnt == 7'h00);
    wire tick_now = stage_hit && !trim_skip &&
        ((s_cnt == 15'h0000) || (trim_extra && s_cnt == 15'h0001));

    // Wakeup counting clock and reload
    wire wk_hit = wakeup_run && wk_clk_hit(wakeup_clock_select, pre_div, tick_now);
    wire wk_long = (wakeup_clock_select[2:1] == 2'b11);
    wire [16:0] wk_load = {wk_long, wakeup_reload_value};
    wire wk_expire = wk_hit && (wk_cnt == 17'h00000);

    // Alarm settings split into fields
    wire al_day_mask = alarm[`AL_DAY_MASK];
    wire al_weekday_sel = alarm[`AL_WEEKDAY_SEL];
    wire [5:0] al_day = alarm[`AL_DAY_HI:`AL_DAY_LO];
    wire [3:0] al_weekday = alarm[`AL_DAY_UNITS_HI:`AL_DAY_LO];
    wire al_hour_mask = alarm[`AL_HOUR_MASK];
    wire [6:0] al_hour = alarm[`AL_HOUR_HI:`AL_HOUR_LO];
    wire al_min_mask = alarm[`AL_MIN_MASK];
    wire [6:0] al_min = alarm[`AL_MIN_HI:`AL_MIN_LO];
    wire al_sec_mask = alarm[`AL_SEC_MASK];
    wire [6:0] al_sec = alarm[`AL_SEC_HI:`AL_SEC_LO];

    // Current calendar in the same layout
    wire [5:0] cur_day = i_cur_time[`AL_DAY_HI:`AL_DAY_LO];
    wire [6:0] cur_hour = i_cur_time[`AL_HOUR_HI:`AL_HOUR_LO];
    wire [6:0] cur_min = i_cur_time[`AL_MIN_HI:`AL_MIN_LO];
    wire [6:0] cur_sec = i_cur_time[`AL_SEC_HI:`AL_SEC_LO];

    // Alarm match on each second tick
    wire day_ok = al_day_mask ||
        (al_weekday_sel ? (i_cur_weekday == al_weekday) : (cur_day == al_day));
    wire hour_ok = field_match(al_hour_mask, cur_hour, al_hour);
    wire min_ok = field_match(al_min_mask, cur_min, al_min);
    wire sec_ok = field_match(al_sec_mask, cur_sec, al_sec);
    wire alarm_hit = tick_now && day_ok && hour_ok && min_ok && sec_ok;

    // Divider factors, write protected by the init state
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            factor_a <= 7'h7F;
            factor_s <= 15'h00FF;
        end else if (wr_div && o_init_state_flag) begin
            factor_a <= i_wdata[`FA_HI:`FA_LO];
            factor_s <= i_wdata[`FS_HI:`FS_LO];
        end
    end

    // Coarse trim, write protected by the init state
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            coarse_trim_direction <= 1'b0;
            coarse_trim_step <= 5'h00;
        end else if (wr_trim && o_init_state_flag) begin
            coarse_trim_direction <= i_wdata[`TRIM_DIR_BIT];
            coarse_trim_step <= i_wdata[`TRIM_STEP_HI:`TRIM_STEP_LO];
        end
    end

    // Alarm settings, write protected by the init state
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            alarm <= `RST_ALARM0;
        end else if (wr_alarm && o_init_state_flag) begin
            alarm <= i_wdata;
        end
    end

    // Wakeup reload, writable only while the timer is stopped
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wakeup_reload_value <= 16'hFFFF;
        end else if (wr_reload && wakeup_write_allowed) begin
            wakeup_reload_value <= i_wdata[15:0];
        end
    end

    // Init mode request
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            init_mode_request <= 1'b0;
        end else if (wr_status) begin
            init_mode_request <= i_wdata[`ST_INIT_REQ];
        end
    end

    // Wakeup control
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wakeup_enable <= 1'b0;
            wakeup_clock_select <= 3'h0;
        end else if (wr_ctrl) begin
            wakeup_enable <= i_wdata[`CT_WAKEUP_EN];
            wakeup_clock_select <= i_wdata[`CT_SEL_HI:`CT_SEL_LO];
        end
    end

    // Init state follows the request one clock later
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_init_state_flag <= 1'b0;
        end else begin
            o_init_state_flag <= init_mode_request;
        end
    end

    // Free-running source divider for the wakeup clock
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_div <= 4'h0;
        end else begin
            pre_div <= pre_div + 4'h1;
        end
    end

    // Registered stage and tick pulses
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_first_stage_clock <= 1'b0;
            o_one_second_tick <= 1'b0;
        end else begin
            o_first_stage_clock <= stage_hit;
            o_one_second_tick <= tick_now;
        end
    end

    // Asynchronous stage counter, held at its factor during init
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            a_cnt <= 7'h7F;
        end else if (o_init_state_flag) begin
            a_cnt <= factor_a;
        end else if (stage_hit) begin
            a_cnt <= factor_a;
        end else begin
            a_cnt <= a_cnt - 7'h01;
        end
    end

    // Synchronous stage counter, stepped once per stage pulse with trim
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_cnt <= 15'h00FF;
        end else if (o_init_state_flag) begin
            s_cnt <= factor_s;
        end else if (stage_hit) begin
            if (tick_now) begin
                s_cnt <= factor_s;
            end else if (trim_extra) begin
                s_cnt <= s_cnt - 15'h0002;
            end else if (!trim_skip) begin
                s_cnt <= s_cnt - 15'h0001;
            end
        end
    end

    // Trim window position in stage pulses
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            win_cnt <= {TRIM_WIN_W{1'b0}};
        end else if (o_init_state_flag) begin
            win_cnt <= {TRIM_WIN_W{1'b0}};
        end else if (stage_hit) begin
            win_cnt <= win_cnt + {{(TRIM_WIN_W-1){1'b0}}, 1'b1};
        end
    end

    // Enable delayed by one clock marks a running timer
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wakeup_run <= 1'b0;
        end else begin
            wakeup_run <= wakeup_enable;
        end
    end

    // Wakeup down-counter, loaded on enable and reloaded on expiry
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wk_cnt <= 17'h00000;
        end else if (wakeup_enable && !wakeup_run) begin
            wk_cnt <= wk_load;
        end else if (wk_hit) begin
            if (wk_expire) begin
                wk_cnt <= wk_load;
            end else begin
                wk_cnt <= wk_cnt - 17'h00001;
            end
        end
    end

    // Wakeup flag: set wins over a software clear in the same cycle
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wakeup_flag <= 1'b0;
        end else if (wk_expire) begin
            o_wakeup_flag <= 1'b1;
        end else if (wr_status && !i_wdata[`ST_WAKEUP_FLAG]) begin
            o_wakeup_flag <= 1'b0;
        end
    end

    // Alarm flag: set wins over a software clear in the same cycle
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_first_alarm_flag <= 1'b0;
        end else if (alarm_hit) begin
            o_first_alarm_flag <= 1'b1;
        end else if (wr_status && !i_wdata[`ST_ALARM_FLAG]) begin
            o_first_alarm_flag <= 1'b0;
        end
    end

    // Read mux
    always @* begin
        next_rdata = 32'h00000000;
        case (i_addr)
            `OFS_WAKEUP_CTRL: begin
                next_rdata[`CT_WAKEUP_EN] = wakeup_enable;
                next_rdata[`CT_SEL_HI:`CT_SEL_LO] = wakeup_clock_select;
            end
            `OFS_STATUS: begin
                next_rdata[`ST_WAKEUP_FLAG] = o_wakeup_flag;
                next_rdata[`ST_ALARM_FLAG] = o_first_alarm_flag;
                next_rdata[`ST_INIT_REQ] = init_mode_request;
                next_rdata[`ST_INIT_FLAG] = o_init_state_flag;
                next_rdata[`ST_WR_ALLOWED] = wakeup_write_allowed;
            end
            `OFS_DIV_FACTORS: begin
                next_rdata[`FA_HI:`FA_LO] = factor_a;
                next_rdata[`FS_HI:`FS_LO] = factor_s;
            end
            `OFS_WAKEUP_RELOAD: begin
                next_rdata[15:0] = wakeup_reload_value;
            end
            `OFS_COARSE_TRIM: begin
                next_rdata[`TRIM_DIR_BIT] = coarse_trim_direction;
                next_rdata[`TRIM_STEP_HI:`TRIM_STEP_LO] = coarse_trim_step;
            end
            `OFS_ALARM0: begin
                next_rdata = alarm;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // Read data stands for one cycle after the read strobe
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule

// *** rtc_map.vh ***
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// Register byte offsets
`define OFS_WAKEUP_CTRL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_DIV_FACTORS 8'h10
`define OFS_WAKEUP_RELOAD 8'h14
`define OFS_COARSE_TRIM 8'h18
`define OFS_ALARM0 8'h1C

// Reset values
`define RST_DIV_FACTORS 32'h007F00FF
`define RST_WAKEUP_RELOAD 32'h0000FFFF
`define RST_COARSE_TRIM 32'h00000000
`define RST_ALARM0 32'h00000000

// Divider factor fields
`define FA_HI 22
`define FA_LO 16
`define FS_HI 14
`define FS_LO 0

// Coarse trim fields
`define TRIM_DIR_BIT 7
`define TRIM_STEP_HI 4
`define TRIM_STEP_LO 0

// Alarm fields
`define AL_DAY_MASK 31
`define AL_WEEKDAY_SEL 30
`define AL_DAY_HI 29
`define AL_DAY_LO 24
`define AL_DAY_UNITS_HI 27
`define AL_HOUR_MASK 23
`define AL_HOUR_HI 22
`define AL_HOUR_LO 16
`define AL_MIN_MASK 15
`define AL_MIN_HI 14
`define AL_MIN_LO 8
`define AL_SEC_MASK 7
`define AL_SEC_HI 6
`define AL_SEC_LO 0

// Status and control fields
`define ST_WAKEUP_FLAG 10
`define ST_ALARM_FLAG 8
`define ST_INIT_REQ 7
`define ST_INIT_FLAG 6
`define ST_WR_ALLOWED 2
`define CT_WAKEUP_EN 10
`define CT_SEL_HI 2
`define CT_SEL_LO 0

// Trim window length in first-stage periods (log2)
`define TRIM_WIN_W 19

`endif

// *** rtc_prescale_wakeup_alarm_asserts.sv ***
`timescale 1ns/1ps
`include "rtc_map.vh"

module rtc_prescale_wakeup_alarm_asserts #(
    parameter TRIM_WIN_W = `TRIM_WIN_W
) (
    input wire i_core_clk,
    input wire i_nrst,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    input wire [31:0] i_cur_time,
    input wire [3:0] i_cur_weekday,
    input wire o_first_stage_clock,
    input wire o_one_second_tick,
    input wire o_wakeup_flag,
    input wire o_first_alarm_flag,
    input wire o_init_state_flag
);
    // Shadows of accepted writes and stage pulse spacing
    reg [6:0] fa;
    reg [7:0] gap;
    reg seen;
    reg wen;
    wire st_wr = i_wr && i_addr == `OFS_STATUS;
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fa <= 7'h7F;
            gap <= 8'h00;
            seen <= 1'b0;
            wen <= 1'b0;
        end else begin
            if (i_wr && i_addr == `OFS_DIV_FACTORS && o_init_state_flag)
                fa <= i_wdata[`FA_HI:`FA_LO];
            if (i_wr && i_addr == `OFS_WAKEUP_CTRL)
                wen <= i_wdata[`CT_WAKEUP_EN];
            gap <= o_first_stage_clock ? 8'h00 : gap + 8'h01;
            seen <= !o_init_state_flag && (seen || o_first_stage_clock);
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    property p_init_follow; st_wr |=> ##1 o_init_state_flag == $past(i_wdata[`ST_INIT_REQ], 2); endproperty
    a_init_follow: assert property (p_init_follow) else $error("init flag not following request");
    property p_stage_period; o_first_stage_clock && seen && !o_init_state_flag |-> gap == {1'b0, fa}; endproperty
    a_stage_period: assert property (p_stage_period) else $error("stage pulse spacing wrong");
    property p_stage_held; o_init_state_flag && $past(o_init_state_flag, 2) |-> !o_first_stage_clock; endproperty
    a_stage_held: assert property (p_stage_held) else $error("stage pulse during init");
    property p_tick_held; o_init_state_flag && $past(o_init_state_flag, 3) |-> !o_one_second_tick; endproperty
    a_tick_held: assert property (p_tick_held) else $error("tick during init");
    property p_wake_keep; o_wakeup_flag && !(st_wr && !i_wdata[`ST_WAKEUP_FLAG]) |=> o_wakeup_flag; endproperty
    a_wake_keep: assert property (p_wake_keep) else $error("wakeup flag dropped");
    property p_wake_clr; st_wr && !i_wdata[`ST_WAKEUP_FLAG] && !wen && !$past(wen) |=> !o_wakeup_flag; endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wakeup flag not cleared");
    property p_alarm_keep; o_first_alarm_flag && !(st_wr && !i_wdata[`ST_ALARM_FLAG]) |=> o_first_alarm_flag; endproperty
    a_alarm_keep: assert property (p_alarm_keep) else $error("alarm flag dropped");
    property p_alarm_clr; st_wr && !i_wdata[`ST_ALARM_FLAG] && o_init_state_flag |=> !o_first_alarm_flag; endproperty
    a_alarm_clr: assert property (p_alarm_clr) else $error("alarm flag not cleared");
endmodule

bind rtc_prescale_wakeup_alarm rtc_prescale_wakeup_alarm_asserts #(.TRIM_WIN_W(TRIM_WIN_W)) u_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_cur_time(i_cur_time), .i_cur_weekday(i_cur_weekday),
    .o_first_stage_clock(o_first_stage_clock), .o_one_second_tick(o_one_second_tick),
    .o_wakeup_flag(o_wakeup_flag), .o_first_alarm_flag(o_first_alarm_flag), .o_init_state_flag(o_init_state_flag));

// *** tb_rtc_prescale_wakeup_alarm.sv ***
`timescale 1ns/1ps
`include "rtc_map.vh"

module tb_rtc_prescale_wakeup_alarm;
    reg i_core_clk = 1'b0;
    reg i_nrst = 1'b0;
    reg [7:0] i_addr = 8'h00;
    reg [31:0] i_wdata = 32'h00000000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg [31:0] i_cur_time = 32'h00000001;
    reg [3:0] i_cur_weekday = 4'h0;
    wire [31:0] o_rdata;
    wire o_first_stage_clock, o_one_second_tick, o_wakeup_flag, o_first_alarm_flag, o_init_state_flag;
    integer n_mismatch = 0, checks = 0, n, s;
    always #50 i_core_clk = ~i_core_clk;
    rtc_prescale_wakeup_alarm #(.TRIM_WIN_W(8)) dut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_cur_time(i_cur_time), .i_cur_weekday(i_cur_weekday),
        .o_first_stage_clock(o_first_stage_clock), .o_one_second_tick(o_one_second_tick),
        .o_wakeup_flag(o_wakeup_flag), .o_first_alarm_flag(o_first_alarm_flag), .o_init_state_flag(o_init_state_flag));
    task stop_test;
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(posedge i_core_clk);
        chk(o_rdata, exp);
    endtask
    function pick(input integer w);
        pick = w == 0 ? o_first_stage_clock : w == 1 ? o_one_second_tick : w == 2 ? o_wakeup_flag : o_first_alarm_flag;
    endfunction
    // Counts edges until the chosen output is seen high
    task gap(input integer w);
        do begin
            @(posedge i_core_clk);
            n = n + 1;
            if (n > 400) begin
                n_mismatch = n_mismatch + 1;
                stop_test;
            end
        end while (pick(w) !== 1'b1);
    endtask
    task period(input integer w, input [31:0] exp);
        n = 0;
        gap(w);
        n = 0;
        gap(w);
        chk(n, exp);
    endtask
    task s_reset;
        rd(`OFS_DIV_FACTORS, 32'h007F00FF);
        rd(`OFS_WAKEUP_RELOAD, 32'h0000FFFF);
        rd(`OFS_COARSE_TRIM, 32'h00000000);
        rd(`OFS_ALARM0, 32'h00000000);
        rd(8'h40, 32'h00000000);
    endtask
    task s_protect;
        wr(`OFS_DIV_FACTORS, 32'h00030004);
        rd(`OFS_DIV_FACTORS, 32'h007F00FF);
        wr(`OFS_STATUS, 32'h00000080);
        @(posedge i_core_clk);
        chk(o_init_state_flag, 32'h00000001);
        wr(`OFS_DIV_FACTORS, 32'h00030004);
        wr(`OFS_COARSE_TRIM, 32'h0000009F);
        rd(`OFS_COARSE_TRIM, 32'h0000009F);
        wr(`OFS_COARSE_TRIM, 32'h0000001F);
        rd(`OFS_COARSE_TRIM, 32'h0000001F);
        wr(`OFS_COARSE_TRIM, 32'h00000000);
        wr(`OFS_ALARM0, 32'h80451234);
        wr(`OFS_STATUS, 32'h00000000);
        wr(`OFS_ALARM0, 32'h00000000);
        rd(`OFS_ALARM0, 32'h80451234);
        rd(`OFS_DIV_FACTORS, 32'h00030004);
        chk(o_init_state_flag, 32'h00000000);
    endtask
    task s_prescale;
        period(0, 32'h00000004);
        period(1, 32'h00000014);
    endtask
    task s_wakeup;
        wr(`OFS_WAKEUP_RELOAD, 32'h00000003);
        for (s = 0; s < 4; s = s + 1) begin
            wr(`OFS_WAKEUP_CTRL, 32'h00000400 | s);
            wr(`OFS_WAKEUP_RELOAD, 32'h00000007);
            rd(`OFS_WAKEUP_RELOAD, 32'h00000003);
            n = 0;
            gap(2);
            wr(`OFS_STATUS, 32'h00000000);
            n = 2;
            gap(2);
            chk(n, 32'h00000040 >> s);
            wr(`OFS_WAKEUP_CTRL, 32'h00000000);
            wr(`OFS_STATUS, 32'h00000000);
        end
        wr(`OFS_WAKEUP_RELOAD, 32'h00000005);
        rd(`OFS_WAKEUP_RELOAD, 32'h00000005);
    endtask
    task s_alarm;
        i_cur_time <= 32'h21051234;
        wr(`OFS_STATUS, 32'h00000000);
        repeat (60) @(posedge i_core_clk);
        chk(o_first_alarm_flag, 32'h00000000);
        i_cur_time <= 32'h21451234;
        n = 0;
        gap(3);
        chk(n < 30, 32'h00000001);
        wr(`OFS_STATUS, 32'h00000180);
        @(posedge i_core_clk);
        wr(`OFS_ALARM0, 32'h53808080);
        i_cur_weekday <= 4'h2;
        wr(`OFS_STATUS, 32'h00000000);
        repeat (60) @(posedge i_core_clk);
        chk(o_first_alarm_flag, 32'h00000000);
        i_cur_weekday <= 4'h3;
        n = 0;
        gap(3);
        chk(n < 30, 32'h00000001);
    endtask
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(posedge i_core_clk);
        s_reset;
        s_protect;
        s_prescale;
        s_wakeup;
        s_alarm;
        stop_test;
    end
endmodule
